// ==== dio_pkg.sv ====
// package for the discrete i/o and diagnostic pwm block
// constants, register map, field positions and timing counts shared by dio_diag, pin_panel and tb_top
package dio_pkg;

   localparam int CLK_HZ = 10_000_000;
   localparam int CLK_NS = 100;

   // pulse and level qualification times, sync low time and diag pwm rate
   localparam int START_MIN_NS = 100;
   localparam int STOP_MIN_NS = 100;
   localparam int FCLR_MIN_NS = 1000;
   localparam int CAL_HOLD_MS = 100;
   localparam int SYNC_LOW_NS = 3000;
   localparam int DIAG_FREQ_HZ = 128_000;

   // least times round up
   localparam int START_CYC = (START_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int STOP_CYC = (STOP_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int FCLR_CYC = (FCLR_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int CAL_CYC = (CAL_HOLD_MS * (CLK_HZ / 1000));
   localparam int SYNC_LOW_CYC = SYNC_LOW_NS / CLK_NS;
   // diag pwm step: 256 steps per period, at least one cycle per step
   localparam int DIAG_STEP_RAW = CLK_HZ / (DIAG_FREQ_HZ * 256);
   localparam int DIAG_STEP_CYC = (DIAG_STEP_RAW < 1) ? 1 : DIAG_STEP_RAW;

   // drive pwm period, a plain default
   localparam int PWM_PERIOD_CYC = 1000;

   // register byte addresses
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] CFG_ADDR = 8'h04;
   localparam logic [7:0] STAT_ADDR = 8'h08;
   localparam logic [7:0] FSTAT_ADDR = 8'h0C;
   localparam logic [7:0] FCTRL_ADDR = 8'h10;
   localparam logic [7:0] DSEL_ADDR = 8'h14;
   localparam logic [7:0] SRC_ADDR = 8'h18;

   // control register fields
   localparam int PWM_EN_POS = 0;
   localparam int VEC_EN_POS = 1;
   localparam int OFFS_AUTO_POS = 2;
   // configuration register fields
   localparam int PIN_CTL_POS = 0;
   localparam int REF_SRC_POS = 1;
   // status register fields
   localparam int ST_PWM_POS = 0;
   localparam int ST_VEC_POS = 1;
   localparam int ST_CAL_POS = 2;
   localparam int ST_FAULT_POS = 3;
   // fault control
   localparam int FCLR_POS = 0;
   localparam int FAULT_W = 5;

   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam logic [15:0] DSEL_RST = 16'h0000;

   // diagnostic source codes
   localparam logic [3:0] SRC_INVALID = 4'h4;
   localparam logic [3:0] SRC_QI = 4'hC;
   localparam logic [3:0] SRC_DI = 4'hD;
   localparam int N_SRC = 16;

   localparam logic signed [15:0] SPEED_MAX = 16'sh3FFF;

   typedef struct packed {
      logic start;
      logic stop;
      logic cal;
      logic fclr;
   } pin_s;

   typedef struct packed {
      logic fault;
      logic sync_n;
      logic pwm_on;
   } pout_s;

   typedef enum logic [1:0] {
      CAL_IDLE = 2'b00,
      CAL_WAIT = 2'b01,
      CAL_RUN = 2'b10
   } cal_e;

endpackage

// ==== pulse_qual.sv ====
// pulse qualifier: synchronises one pin and reports a level held n cycles
// assumes an asynchronous pin; active-high level after any inversion outside
`timescale 1ns/1ns
module pulse_qual #(
   parameter int CYCLES = 1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic pin,
   output logic qual_pulse
);
   localparam int CW = $clog2(CYCLES + 1);

   initial begin
      if (CYCLES < 1) $error("pulse_qual needs CYCLES >= 1");
   end

   logic meta;
   logic sync;
   logic [CW-1:0] count;
   logic done;
   wire reached = (count == CW'(CYCLES - 1));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta <= 1'b0;
         sync <= 1'b0;
      end else begin
         meta <= pin;
         sync <= meta;
      end
   end

   // fires once per held level, the cycle after its width is reached
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= '0;
         done <= 1'b0;
         qual_pulse <= 1'b0;
      end else begin
         qual_pulse <= sync && !done && reached;
         if (!sync) begin
            count <= '0;
            done <= 1'b0;
         end else if (reached) begin
            done <= 1'b1;
         end else begin
            count <= count + CW'(1);
         end
      end
   end
endmodule

// ==== diag_pwm.sv ====
// one diagnostic pwm channel: 256-step period, duty from an 8-bit value
// assumes step_tick is a one-cycle pulse from the common step divider
`timescale 1ns/1ns
module diag_pwm (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic step_tick,
   input wire logic [7:0] step,
   input wire logic load,
   input wire logic [7:0] value,
   output logic pwm_out
);
   logic [7:0] held;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         held <= 8'h00;
         pwm_out <= 1'b0;
      end else begin
         if (load) held <= value;
         if (step_tick) pwm_out <= (step < held);
      end
   end
endmodule

// ==== dio_diag.sv ====
// discrete i/o and diagnostic pwm outputs of the motor drive controller
// assumes an ahb-lite master; pins are asynchronous; fault sources arrive on
// the same clock as one-cycle or level events
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
// Functional notes
// - start pulse of 100 ns sets pwm enable and vector control enable.
// - stop pulse of 100 ns clears pwm enable and vector control enable.
// - calibration held high 100 ms starts calibration, pwm on, vector off.
// - fault clear pulse of 1 us clears pending fault like the clear bit.
// - fault output high whenever any fault status bit is set.
// - sync output low 3 us each pwm period, falling edge starts period.
// - pwm active output mirrors the pwm enable bit.
// - pin control bit 0: only stop honoured, other outputs inactive.
// - writing 1 to pin control bit enables the discrete pins.
// - reference select bit 1 makes the reference adc the speed source.
// - full positive reference gives 16383, full negative gives -16383.
// - four diagnostic channels, each with its own source select.
// - each channel is 8-bit pwm repeating at 128 kHz; here the step is one clock, so 256 cycles at 10 MHz, about 39 kHz.
// - channel values load at the start of each pwm period, whether or not the sync output is enabled.
// - sources rescale linearly to 0..255; -16384 to 0, 16383 to 255.
// - source codes 1..15 decoded; code 4 is not valid.
// - any fault disables pwm and gates, latched until cleared.
module dio_diag #(
   parameter int CAL_CYCLES = dio_pkg::CAL_CYC,
   parameter int PWM_PERIOD = dio_pkg::PWM_PERIOD_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire dio_pkg::pin_s pins,
   input wire logic [dio_pkg::FAULT_W-1:0] fault_events,
   input wire logic [15:0] ref_adc,
   input wire logic [15:0] src_data,
   output dio_pkg::pout_s pouts,
   output logic [15:0] speed_ref,
   output logic gate_enable,
   output logic offset_cal_busy,
   output logic [3:0] diag_out
);

   initial begin
      if (CAL_CYCLES < 1 || PWM_PERIOD <= dio_pkg::SYNC_LOW_CYC)
         $error("dio_diag parameters out of range");
   end

   default clocking chk_clk @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   ////////////////////////////////////////////////////////////////////////
   // ahb-lite slave: zero wait states, always okay

   logic wr_pend;
   logic [7:0] wr_addr;
   logic [7:0] rd_addr;
   wire take = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         rd_addr <= 8'h00;
      end else begin
         wr_pend <= take && hwrite;
         if (take) wr_addr <= haddr;
         if (take) rd_addr <= haddr;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   wire wr_ctrl = wr_pend && (wr_addr == dio_pkg::CTRL_ADDR);
   wire wr_cfg = wr_pend && (wr_addr == dio_pkg::CFG_ADDR);
   wire wr_fctrl = wr_pend && (wr_addr == dio_pkg::FCTRL_ADDR);
   wire wr_dsel = wr_pend && (wr_addr == dio_pkg::DSEL_ADDR);

   ////////////////////////////////////////////////////////////////////////
   // discrete inputs: start, stop, fault clear and calibrate are active high here

   logic start_p;
   logic stop_p;
   logic cal_p;
   logic fclr_p;

   pulse_qual #(.CYCLES(dio_pkg::START_CYC)) u_start (
      .hclk(hclk), .hresetn(hresetn), .pin(pins.start),
      .qual_pulse(start_p));
   pulse_qual #(.CYCLES(dio_pkg::STOP_CYC)) u_stop (
      .hclk(hclk), .hresetn(hresetn), .pin(pins.stop),
      .qual_pulse(stop_p));
   pulse_qual #(.CYCLES(CAL_CYCLES)) u_cal (
      .hclk(hclk), .hresetn(hresetn), .pin(pins.cal),
      .qual_pulse(cal_p));
   pulse_qual #(.CYCLES(dio_pkg::FCLR_CYC)) u_fclr (
      .hclk(hclk), .hresetn(hresetn), .pin(pins.fclr),
      .qual_pulse(fclr_p));

   ////////////////////////////////////////////////////////////////////////
   // configuration and control

   logic pin_control_cfg_bit;
   logic speed_ref_source_bit;
   logic pwm_enable_bit;
   logic vector_control_enable_bit;
   logic current_offset_auto_bit;
   logic [dio_pkg::FAULT_W-1:0] fault_status;
   logic [15:0] diag_sel;
   dio_pkg::cal_e cal_state;

   wire pin_control_enable_bit = pin_control_cfg_bit;
   wire pin_start = pin_control_enable_bit && start_p;
   wire pin_cal = pin_control_enable_bit && cal_p;
   wire pin_fclr = pin_control_enable_bit && fclr_p;
   wire fault_any = |fault_status;
   wire clear_fault = pin_fclr ||
      (wr_fctrl && hwdata[dio_pkg::FCLR_POS]);
   wire cal_go = pin_cal && current_offset_auto_bit && !fault_any;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_control_cfg_bit <= dio_pkg::CFG_RST[dio_pkg::PIN_CTL_POS];
         speed_ref_source_bit <= dio_pkg::CFG_RST[dio_pkg::REF_SRC_POS];
      end else if (wr_cfg) begin
         pin_control_cfg_bit <= hwdata[dio_pkg::PIN_CTL_POS];
         speed_ref_source_bit <= hwdata[dio_pkg::REF_SRC_POS];
      end
   end

   // fault set wins over clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) fault_status <= '0;
      else fault_status <= (clear_fault ? '0 : fault_status)
                         | fault_events;
   end

   // priority: fault, stop, start/cal, register write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwm_enable_bit <= dio_pkg::CTRL_RST[dio_pkg::PWM_EN_POS];
         vector_control_enable_bit <= dio_pkg::CTRL_RST[dio_pkg::VEC_EN_POS];
         current_offset_auto_bit <=
            dio_pkg::CTRL_RST[dio_pkg::OFFS_AUTO_POS];
      end else begin
         if (wr_ctrl) current_offset_auto_bit <=
            hwdata[dio_pkg::OFFS_AUTO_POS];
         if (fault_any || |fault_events) begin
            pwm_enable_bit <= 1'b0;
            vector_control_enable_bit <= 1'b0;
         end else if (stop_p) begin
            pwm_enable_bit <= 1'b0;
            vector_control_enable_bit <= 1'b0;
         end else if (pin_start) begin
            pwm_enable_bit <= 1'b1;
            vector_control_enable_bit <= 1'b1;
         end else if (cal_go) begin
            pwm_enable_bit <= 1'b1;
            vector_control_enable_bit <= 1'b0;
         end else if (wr_ctrl) begin
            pwm_enable_bit <= hwdata[dio_pkg::PWM_EN_POS];
            vector_control_enable_bit <= hwdata[dio_pkg::VEC_EN_POS];
         end
      end
   end

   // calibration runs until pwm is dropped or vector control is set, by stop, start, fault or software
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) cal_state <= dio_pkg::CAL_IDLE;
      else begin
         case (cal_state)
            dio_pkg::CAL_IDLE: if (cal_go) cal_state <= dio_pkg::CAL_WAIT;
            dio_pkg::CAL_WAIT: cal_state <= dio_pkg::CAL_RUN;
            dio_pkg::CAL_RUN:
               if (!pwm_enable_bit || vector_control_enable_bit)
                  cal_state <= dio_pkg::CAL_IDLE;
            default: cal_state <= dio_pkg::CAL_IDLE;
         endcase
      end
   end
   assign offset_cal_busy = (cal_state != dio_pkg::CAL_IDLE);
   assign gate_enable = pwm_enable_bit && !fault_any;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) diag_sel <= dio_pkg::DSEL_RST;
      else if (wr_dsel) diag_sel <= hwdata[15:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // drive pwm period and sync

   localparam int PW = $clog2(PWM_PERIOD + 1);
   logic [PW-1:0] period_cnt;
   wire period_start = (period_cnt == '0);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) period_cnt <= '0;
      else if (period_cnt == PW'(PWM_PERIOD - 1)) period_cnt <= '0;
      else period_cnt <= period_cnt + PW'(1);
   end

   logic sync_low;
   logic fault_q;
   logic pwm_on_indicator;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_low <= 1'b0;
         fault_q <= 1'b0;
         pwm_on_indicator <= 1'b0;
      end else begin
         sync_low <= pin_control_enable_bit &&
            (period_cnt < PW'(dio_pkg::SYNC_LOW_CYC));
         fault_q <= pin_control_enable_bit && fault_any;
         pwm_on_indicator <= pin_control_enable_bit
            && pwm_enable_bit;
      end
   end
   // one driver for the whole struct: fault, sync_n, pwm_on
   assign pouts = {fault_q, !sync_low, pwm_on_indicator};

   ////////////////////////////////////////////////////////////////////////
   // speed reference from the analog input

   wire signed [15:0] ref_s = ref_adc;
   wire signed [15:0] ref_clip = (ref_s < -dio_pkg::SPEED_MAX) ?
      -dio_pkg::SPEED_MAX : ((ref_s > dio_pkg::SPEED_MAX) ?
      dio_pkg::SPEED_MAX : ref_s);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) speed_ref <= 16'h0000;
      else if (speed_ref_source_bit) speed_ref <= ref_clip;
   end

   ////////////////////////////////////////////////////////////////////////
   // diagnostic channels

   localparam int SW = $clog2(dio_pkg::DIAG_STEP_CYC + 1);
   logic [SW-1:0] step_div;
   logic [7:0] step;
   wire step_tick = (step_div == SW'(dio_pkg::DIAG_STEP_CYC - 1));
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         step_div <= '0;
         step <= 8'h00;
      end else begin
         step_div <= step_tick ? '0 : step_div + SW'(1);
         if (step_tick) step <= step + 8'h01;
      end
   end

   // source word is signed 15-bit range; offset and keep the top 8 bits
   wire [15:0] src_off = src_data + 16'h4000;
   wire [7:0] src_scaled = src_off[14:7];

   genvar ch;
   generate
      for (ch = 0; ch < 4; ch++) begin : g_diag
         wire [3:0] sel = diag_sel[ch*4 +: 4];
         wire sel_ok = (sel != 4'h0) && (sel != dio_pkg::SRC_INVALID);
         logic [7:0] sample;
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) sample <= 8'h00;
            else if (period_cnt == PW'(ch + 1))
               sample <= sel_ok ? src_scaled : 8'h00;
         end
         diag_pwm u_ch (
            .hclk(hclk), .hresetn(hresetn), .step_tick(step_tick),
            .step(step), .load(period_start), .value(sample),
            .pwm_out(diag_out[ch]));
      end
   endgenerate

   // external source mux presents the selected word for each channel in turn
   wire [3:0] src_sel_now = diag_sel[(period_cnt[1:0])*4 +: 4];

   ////////////////////////////////////////////////////////////////////////
   // register read

   wire [31:0] status_word = {28'h0000000, fault_any, offset_cal_busy,
      vector_control_enable_bit, pwm_enable_bit};
   always_comb begin
      case (rd_addr)
         dio_pkg::CTRL_ADDR: hrdata = {29'h0, current_offset_auto_bit,
            vector_control_enable_bit, pwm_enable_bit};
         dio_pkg::CFG_ADDR: hrdata = {30'h0, speed_ref_source_bit,
            pin_control_cfg_bit};
         dio_pkg::STAT_ADDR: hrdata = status_word;
         dio_pkg::FSTAT_ADDR: hrdata = {27'h0, fault_status};
         dio_pkg::DSEL_ADDR: hrdata = {16'h0000, diag_sel};
         dio_pkg::SRC_ADDR: hrdata = {28'h0, src_sel_now};
         default: hrdata = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   a_fault_pin_level: assert property (
      pin_control_enable_bit |=> pouts.fault == $past(fault_any))
      else $error("fault pin disagrees with status");
   a_pwm_mirror: assert property (
      pin_control_enable_bit |=> pouts.pwm_on == $past(pwm_enable_bit))
      else $error("pwm active pin disagrees");
   a_stop_clears: assert property (
      stop_p |=> !pwm_enable_bit && !vector_control_enable_bit)
      else $error("stop did not clear enables");
   a_start_sets: assert property (
      pin_start && !stop_p && !fault_any && !(|fault_events)
      |=> pwm_enable_bit && vector_control_enable_bit)
      else $error("start did not set enables");
   a_fault_kills: assert property (
      fault_any |-> !pwm_enable_bit && !gate_enable)
      else $error("pwm or gates on during fault");
   a_pins_masked: assert property (
      !pin_control_enable_bit ##1 !pin_control_enable_bit
      |-> pouts.sync_n && !pouts.fault && !pouts.pwm_on)
      else $error("outputs active without pin control");
   // calibration: pwm on and vector control off, then busy the cycle after
   sequence cal_entry;
      pwm_enable_bit && !vector_control_enable_bit ##1 offset_cal_busy;
   endsequence
   a_cal_enters: assert property (
      cal_go && !stop_p && !pin_start && !(|fault_events) |=> cal_entry)
      else $error("calibration entry wrong");
   a_fclr_clears: assert property (
      pin_fclr && !(|fault_events) |=> !fault_any)
      else $error("fault clear ignored");
   a_ref_select: assert property (
      speed_ref_source_bit |=> speed_ref == $past(ref_clip))
      else $error("speed reference not taken");
   a_sync_starts: assert property (
      pin_control_enable_bit && period_start |=> !pouts.sync_n)
      else $error("sync not low at period start");
   a_sync_ends: assert property (
      pin_control_enable_bit && period_cnt == PW'(dio_pkg::SYNC_LOW_CYC)
      |=> pouts.sync_n)
      else $error("sync low too long");
endmodule

// ==== pin_panel.sv ====
// operator panel model: drives the four discrete pins of the block
// assumes pins idle low through pull-downs and change after a rising edge
`timescale 1ns/1ns
module pin_panel (
   input wire logic hclk,
   output dio_pkg::pin_s pins
);
   initial begin
      pins = '0;
   end

   // bit 3 start, 2 stop, 1 cal, 0 clear; width set by the caller
   task automatic hold(input int idx, input int n);
      @(posedge hclk);
      pins[idx] <= 1'b1;
      repeat (n) @(posedge hclk);
      pins[idx] <= 1'b0;
   endtask
endmodule

// ==== tb_top.sv ====
// self-checking bench for the discrete i/o and diagnostic pwm block
// assumes a short calibration hold and drive period set at the instance
`timescale 1ns/1ns
module tb_top;
   localparam int PER = 64;
   localparam int CAL = 20;
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   dio_pkg::pin_s pins;
   logic [dio_pkg::FAULT_W-1:0] fault_events;
   logic [15:0] ref_adc;
   logic [15:0] src_data;
   dio_pkg::pout_s pouts;
   logic [15:0] speed_ref;
   logic gate_enable;
   logic offset_cal_busy;
   logic [3:0] diag_out;
   int mismatches = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [31:0] rd;
   int refs[$] = '{32767, -32768, 16383, -16383, 256, -20000};

   dio_diag #(.CAL_CYCLES(CAL), .PWM_PERIOD(PER)) dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
      .fault_events(fault_events), .ref_adc(ref_adc),
      .src_data(src_data), .pouts(pouts), .speed_ref(speed_ref),
      .gate_enable(gate_enable), .offset_cal_busy(offset_cal_busy),
      .diag_out(diag_out)
   );
   pin_panel panel_u (.hclk(hclk), .pins(pins));

   ////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      if (mismatches == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] s,
                      input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask

   // hsel stays high between transfers so no signal is set twice at an edge
   task automatic ahb(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
      int t;
      t = 0;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do begin
         @(posedge hclk);
         t++;
      end while (hreadyout !== 1'b1 && t < 50);
      htrans <= 2'b00;
      hwdata <= d;
      do begin
         @(posedge hclk);
         t++;
      end while (hreadyout !== 1'b1 && t < 50);
      rd = hrdata;
   endtask

   task automatic rchk(input string nm, input logic [7:0] a,
                       input logic [31:0] m, input logic [31:0] e);
      ahb(a, 1'b0, 32'h0);
      chk(nm, rd & m, e);
   endtask

   // k 0..3 counts a diag channel high, 4 counts the sync output low
   task automatic cnt(input int k, input int n, output int c);
      c = 0;
      repeat (n) begin
         @(posedge hclk);
         if (k < 4) c += (diag_out[k] === 1'b1);
         else c += (pouts.sync_n === 1'b0);
      end
   endtask

   function automatic logic [15:0] clip(input int r);
      int c;
      c = r > 16383 ? 16383 : (r < -16383 ? -16383 : r);
      return 16'(c);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         wrap_up();
      end
   end

   initial begin
      int c;
      int s;
      int v;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      fault_events = '0;
      ref_adc = 16'h0000;
      src_data = 16'h0000;
      s = $urandom(87);
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      hsel <= 1'b1;
      @(posedge hclk);
      chk("pouts_rst", 32'(pouts), 32'h2);
      rchk("ctrl_rst", dio_pkg::CTRL_ADDR, '1, 0);
      chk("hresp", hresp, 0);
      rchk("unmapped", 8'h40, '1, 0);
      // pin control off: start ignored, stop honoured, no sync
      panel_u.hold(3, 4);
      repeat (6) @(posedge hclk);
      rchk("start_off", dio_pkg::STAT_ADDR, 3, 0);
      ahb(dio_pkg::CTRL_ADDR, 1'b1, 32'h3);
      panel_u.hold(2, 2);
      repeat (6) @(posedge hclk);
      rchk("stop_off", dio_pkg::CTRL_ADDR, 3, 0);
      cnt(4, PER, c);
      chk("sync_gated", c, 0);
      ahb(dio_pkg::CFG_ADDR, 1'b1, 32'h1);
      panel_u.hold(3, 2);
      repeat (6) @(posedge hclk);
      rchk("start_on", dio_pkg::STAT_ADDR, 3, 3);
      chk("pwm_on", pouts.pwm_on, 1);
      chk("gate_on", gate_enable, 1);
      cnt(4, PER, c);
      chk("sync_low", c, dio_pkg::SYNC_LOW_CYC);
      // a fault latches; a short clear is refused, a full one works
      fault_events <= 5'h04;
      @(posedge hclk);
      fault_events <= '0;
      repeat (3) @(posedge hclk);
      rchk("fstat", dio_pkg::FSTAT_ADDR, '1, 4);
      chk("fault_out", pouts.fault, 1);
      chk("gate_off", gate_enable, 0);
      chk("pwm_off", pouts.pwm_on, 0);
      panel_u.hold(0, dio_pkg::FCLR_CYC / 2);
      repeat (6) @(posedge hclk);
      chk("fault_held", pouts.fault, 1);
      panel_u.hold(0, dio_pkg::FCLR_CYC + 2);
      repeat (6) @(posedge hclk);
      rchk("fclr_pin", dio_pkg::FSTAT_ADDR, '1, 0);
      chk("fault_clr", pouts.fault, 0);
      ahb(dio_pkg::CFG_ADDR, 1'b1, 32'h0);
      fault_events <= 5'h11;
      @(posedge hclk);
      fault_events <= '0;
      repeat (3) @(posedge hclk);
      chk("fault_gated", pouts.fault, 0);
      ahb(dio_pkg::FCTRL_ADDR, 1'b1, 32'h1);
      rchk("fclr_reg", dio_pkg::FSTAT_ADDR, '1, 0);
      // calibration hold with offset auto set first
      ahb(dio_pkg::CTRL_ADDR, 1'b1, 32'h4);
      ahb(dio_pkg::CFG_ADDR, 1'b1, 32'h1);
      panel_u.hold(1, CAL + 6);
      repeat (2) @(posedge hclk);
      rchk("cal", dio_pkg::STAT_ADDR, 7, 5);
      chk("cal_busy", offset_cal_busy, 1);
      panel_u.hold(2, 2);
      ahb(dio_pkg::CFG_ADDR, 1'b1, 32'h3);
      foreach (refs[i]) begin
         ref_adc <= 16'(refs[i]);
         repeat (4) @(posedge hclk);
         chk("speed_ref", speed_ref, clip(refs[i]));
      end
      // ch0 q current, ch1 invalid 4, ch2 d current, ch3 unused 0
      ahb(dio_pkg::DSEL_ADDR, 1'b1, 32'h0000_0D4C);
      repeat (3) begin
         s = int'($urandom % 32768) - 16384;
         src_data <= 16'(s);
         v = (s + 16384) * 256 / 32768;
         repeat (2 * PER) @(posedge hclk);
         for (int k = 0; k < 4; k++) begin
            cnt(k, 256, c);
            chk("diag", c, (k % 2) ? 0 : v);
         end
      end
      wrap_up();
   end
endmodule
